// File: design/brs_params.svh
// offsets, field positions, reset values and timing counts of the run-state sequencer
`ifndef BRS_PARAMS_SVH
`define BRS_PARAMS_SVH

// register byte offsets
`define BRS_OFF_CTRL 12'h000
`define BRS_OFF_SP_ASSIST 12'h004
`define BRS_OFF_SP_WASTE 12'h008
`define BRS_OFF_SP_PROCESS 12'h00c
`define BRS_OFF_SP_LOWFIRE 12'h010
`define BRS_OFF_TIMES 12'h014
`define BRS_OFF_STATUS 12'h018

// control register fields
`define BRS_CTRL_POM_LSB 0
`define BRS_CTRL_LHS_LSB 2
`define BRS_CTRL_AUX_PID 4
`define BRS_CTRL_RELIGHT_EN 5
`define BRS_CTRL_LIMIT_LSB 8
`define BRS_CTRL_CLR_COUNT 31
`define BRS_CTRL_RESET 32'h0000_0300

// timing register fields, both in milliseconds
`define BRS_TIMES_LHS_LSB 0
`define BRS_TIMES_RELIGHT_LSB 16
`define BRS_TIMES_RESET 32'h2710_ea60

// status register fields
`define BRS_STAT_STATE_LSB 0
`define BRS_STAT_COUNT_LSB 8
`define BRS_STAT_OUT_LSB 16

// setpoint reset value
`define BRS_SP_RESET 16'h0000

// time base: one millisecond tick
`define BRS_CLK_NS 50
`define BRS_TICK_NS 1000000
`define BRS_TICK_CYCLES (`BRS_TICK_NS / `BRS_CLK_NS)

`endif

// File: design/brs_pkg.sv
// types shared by the run-state sequencer
package brs_pkg;

   typedef enum logic [2:0] {
      BRS_LOCKOUT,
      BRS_WAITING,
      BRS_PILOT,
      BRS_LOW_FIRE,
      BRS_INCINERATE,
      BRS_INCIN_NO_ASSIST,
      BRS_PID_CONTROL
   } brs_state_e;

   typedef enum logic [1:0] {
      BRS_POM_DISABLED,
      BRS_POM_OFF_AT_SETPOINT,
      BRS_POM_OFF_AFTER_MAIN_ON,
      BRS_POM_FOLLOW_MAIN
   } brs_pilot_off_e;

   typedef enum logic [1:0] {
      BRS_LHS_DISABLED,
      BRS_LHS_WAIT,
      BRS_LHS_MAIN_PERMISSIVE,
      BRS_LHS_RESERVED
   } brs_lhs_e;

   typedef struct packed {
      logic alarm;
      logic wait_cond;
      logic main_permissive;
      logic flame_loss;
      logic user_stop;
   } brs_cond_s;

   typedef struct packed {
      logic pilot;
      logic first_fuel_shutoff_valve;
      logic second_fuel_shutoff_valve;
      logic pilot_valve;
      logic ignition_coil;
      logic ignition_enable;
   } brs_safety_s;

endpackage

// File: design/brs_run_seq.sv
// run-state sequencer: state machine, safety outputs and apb register file
`timescale 1ns/1ps
`default_nettype none
`include "brs_params.svh"

module brs_run_seq #(
   parameter int unsigned TICK_CYCLES = `BRS_TICK_CYCLES
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire brs_pkg::brs_cond_s cond_in,
   input wire logic [15:0] process_temp_in,
   input wire logic ext_load_in,
   input wire brs_pkg::brs_state_e ext_state_in,
   output brs_pkg::brs_state_e state_out,
   output brs_pkg::brs_safety_s safety_out
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   brs_pkg::brs_state_e state;
   brs_pkg::brs_state_e next_state;
   logic [31:0] ctrl;
   logic [31:0] times;
   logic [15:0] sp_assist;
   logic [15:0] sp_waste;
   logic [15:0] sp_process;
   logic [15:0] sp_lowfire;
   logic [3:0] relight_count;
   logic [15:0] tick_cnt;
   logic tick;
   logic [15:0] lhs_ms;
   logic [15:0] relight_ms;
   logic reigniting;
   brs_pkg::brs_pilot_off_e pom;
   brs_pkg::brs_lhs_e lhs_mode;
   logic [3:0] relight_limit;
   logic relight_exceeded;
   logic any_block;
   logic go_lockout;
   logic go_waiting;
   logic go_pilot;
   logic pom_waits;
   logic pilot_dropped;
   logic running;
   logic in_band;
   logic lhs_elapsed;
   logic flame_event;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic clr_count;
   brs_pkg::brs_safety_s next_safety;

   ////////////////////////////////////////////////////////////////////////////
   // decoded settings

   assign pom = brs_pkg::brs_pilot_off_e'(ctrl[`BRS_CTRL_POM_LSB +: 2]);
   assign lhs_mode = brs_pkg::brs_lhs_e'(ctrl[`BRS_CTRL_LHS_LSB +: 2]);
   assign relight_limit = ctrl[`BRS_CTRL_LIMIT_LSB +: 4];
   assign pom_waits = (pom == brs_pkg::BRS_POM_OFF_AFTER_MAIN_ON) ||
      (pom == brs_pkg::BRS_POM_FOLLOW_MAIN);
   assign pilot_dropped = (pom == brs_pkg::BRS_POM_OFF_AFTER_MAIN_ON);

   ////////////////////////////////////////////////////////////////////////////
   // exit conditions shared by the covered running states

   assign running = (state == brs_pkg::BRS_INCIN_NO_ASSIST) ||
      (state == brs_pkg::BRS_PID_CONTROL);
   // attempts already used up to the limit count as exceeded
   assign relight_exceeded = (relight_count >= relight_limit);
   assign any_block = cond_in.alarm | cond_in.wait_cond | cond_in.main_permissive;
   assign go_lockout = cond_in.alarm | cond_in.user_stop |
      (cond_in.flame_loss & relight_exceeded);
   assign go_waiting = cond_in.wait_cond |
      (cond_in.flame_loss & ~relight_exceeded) |
      (cond_in.main_permissive & pom_waits);
   assign go_pilot = cond_in.main_permissive & ~pom_waits;
   assign flame_event = running & cond_in.flame_loss & ~relight_exceeded &
      ~cond_in.alarm & ~cond_in.user_stop;
   assign in_band = (process_temp_in > sp_process) && (process_temp_in < sp_lowfire);
   assign lhs_elapsed = (lhs_ms >= times[`BRS_TIMES_LHS_LSB +: 16]);

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_state = state;
      case (state)
         brs_pkg::BRS_INCINERATE: begin
            if (!any_block && process_temp_in > sp_assist) begin
               next_state = brs_pkg::BRS_INCIN_NO_ASSIST;
            end
         end
         brs_pkg::BRS_LOW_FIRE: begin
            if (!any_block && process_temp_in < sp_process && ctrl[`BRS_CTRL_AUX_PID]) begin
               next_state = brs_pkg::BRS_PID_CONTROL;
            end
         end
         brs_pkg::BRS_INCIN_NO_ASSIST: begin
            if (go_lockout) begin
               next_state = brs_pkg::BRS_LOCKOUT;
            end else if (go_waiting) begin
               next_state = brs_pkg::BRS_WAITING;
            end else if (go_pilot) begin
               next_state = brs_pkg::BRS_PILOT;
            end else if (process_temp_in > sp_waste) begin
               next_state = pom_waits ? brs_pkg::BRS_WAITING : brs_pkg::BRS_PILOT;
            end else if (process_temp_in < sp_assist) begin
               next_state = brs_pkg::BRS_INCINERATE;
            end
         end
         brs_pkg::BRS_PID_CONTROL: begin
            if (go_lockout) begin
               next_state = brs_pkg::BRS_LOCKOUT;
            end else if (go_waiting) begin
               next_state = brs_pkg::BRS_WAITING;
            end else if (in_band && lhs_elapsed && lhs_mode == brs_pkg::BRS_LHS_WAIT) begin
               next_state = brs_pkg::BRS_WAITING;
            end else if (go_pilot) begin
               next_state = brs_pkg::BRS_PILOT;
            end else if (in_band && lhs_elapsed &&
                  lhs_mode == brs_pkg::BRS_LHS_MAIN_PERMISSIVE) begin
               next_state = brs_pkg::BRS_PILOT;
            end else if (process_temp_in > sp_lowfire) begin
               next_state = pom_waits ? brs_pkg::BRS_WAITING : brs_pkg::BRS_PILOT;
            end
         end
         default: begin
            next_state = state;
         end
      endcase
      // the surrounding sequencer owns every state outside the two covered ones
      if (ext_load_in && !running) begin
         next_state = ext_state_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= brs_pkg::BRS_LOCKOUT;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // millisecond time base

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_cnt <= 16'h0000;
      end else if (tick) begin
         tick_cnt <= 16'h0000;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////
   // low heat standby delay: restarts whenever pid leaves the band

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lhs_ms <= 16'h0000;
      end else if (state != brs_pkg::BRS_PID_CONTROL || !in_band ||
            lhs_mode == brs_pkg::BRS_LHS_DISABLED) begin
         lhs_ms <= 16'h0000;
      end else if (tick && !lhs_elapsed) begin
         lhs_ms <= lhs_ms + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // relight attempts and reignition window

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         relight_count <= 4'h0;
      end else if (flame_event && relight_count != 4'hf) begin
         // a flame loss in the clearing cycle still counts
         relight_count <= relight_count + 4'h1;
      end else if (clr_count) begin
         relight_count <= 4'h0;
      end
   end

   // a reignition window opens on a relightable flame loss when relight is enabled
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reigniting <= 1'b0;
         relight_ms <= 16'h0000;
      end else if (flame_event && ctrl[`BRS_CTRL_RELIGHT_EN]) begin
         reigniting <= 1'b1;
         relight_ms <= 16'h0000;
      end else if (reigniting) begin
         if (relight_ms >= times[`BRS_TIMES_RELIGHT_LSB +: 16] || cond_in.alarm ||
               cond_in.user_stop || state == brs_pkg::BRS_LOCKOUT) begin
            reigniting <= 1'b0;
         end else if (tick) begin
            relight_ms <= relight_ms + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // safety outputs, registered so they never glitch

   always_comb begin
      next_safety = '0;
      case (next_state)
         brs_pkg::BRS_INCIN_NO_ASSIST: begin
            next_safety.pilot = ~pilot_dropped;
            next_safety.second_fuel_shutoff_valve = 1'b1;
            next_safety.pilot_valve = ~pilot_dropped;
         end
         brs_pkg::BRS_PID_CONTROL,
         brs_pkg::BRS_INCINERATE,
         brs_pkg::BRS_LOW_FIRE: begin
            next_safety.pilot = ~pilot_dropped;
            next_safety.first_fuel_shutoff_valve = 1'b1;
            next_safety.second_fuel_shutoff_valve = 1'b1;
            next_safety.pilot_valve = ~pilot_dropped;
         end
         brs_pkg::BRS_PILOT: begin
            next_safety.pilot = 1'b1;
            next_safety.pilot_valve = 1'b1;
         end
         default: begin
            next_safety = '0;
         end
      endcase
      if (next_state != brs_pkg::BRS_LOCKOUT) begin
         next_safety.ignition_coil = reigniting;
         next_safety.ignition_enable = reigniting;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         safety_out <= '0;
      end else begin
         safety_out <= next_safety;
      end
   end

   assign state_out = state;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, read data captured in the setup cycle

   assign wr_en = psel_in & penable_in & pwrite_in;
   assign rd_en = psel_in & ~penable_in & ~pwrite_in;
   assign addr_ok = (paddr_in == `BRS_OFF_CTRL) || (paddr_in == `BRS_OFF_SP_ASSIST) ||
      (paddr_in == `BRS_OFF_SP_WASTE) || (paddr_in == `BRS_OFF_SP_PROCESS) ||
      (paddr_in == `BRS_OFF_SP_LOWFIRE) || (paddr_in == `BRS_OFF_TIMES) ||
      (paddr_in == `BRS_OFF_STATUS);
   assign clr_count = wr_en && paddr_in == `BRS_OFF_CTRL && pwdata_in[`BRS_CTRL_CLR_COUNT];
   assign pready_out = 1'b1;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl <= `BRS_CTRL_RESET;
         times <= `BRS_TIMES_RESET;
      end else if (wr_en) begin
         if (paddr_in == `BRS_OFF_CTRL) begin
            // clear-count bit is a strobe and reads back as zero
            ctrl <= {1'b0, 19'h00000, pwdata_in[11:8], 2'b00, pwdata_in[5:0]};
         end
         if (paddr_in == `BRS_OFF_TIMES) begin
            times <= pwdata_in;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sp_assist <= `BRS_SP_RESET;
         sp_waste <= `BRS_SP_RESET;
         sp_process <= `BRS_SP_RESET;
         sp_lowfire <= `BRS_SP_RESET;
      end else if (wr_en) begin
         case (paddr_in)
            `BRS_OFF_SP_ASSIST: sp_assist <= pwdata_in[15:0];
            `BRS_OFF_SP_WASTE: sp_waste <= pwdata_in[15:0];
            `BRS_OFF_SP_PROCESS: sp_process <= pwdata_in[15:0];
            `BRS_OFF_SP_LOWFIRE: sp_lowfire <= pwdata_in[15:0];
            default: sp_assist <= sp_assist;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prdata_out <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (psel_in && !penable_in) begin
         pslverr_out <= ~addr_ok;
         prdata_out <= 32'h0000_0000;
         if (rd_en) begin
            case (paddr_in)
               `BRS_OFF_CTRL: prdata_out <= ctrl;
               `BRS_OFF_SP_ASSIST: prdata_out <= {16'h0000, sp_assist};
               `BRS_OFF_SP_WASTE: prdata_out <= {16'h0000, sp_waste};
               `BRS_OFF_SP_PROCESS: prdata_out <= {16'h0000, sp_process};
               `BRS_OFF_SP_LOWFIRE: prdata_out <= {16'h0000, sp_lowfire};
               `BRS_OFF_TIMES: prdata_out <= times;
               `BRS_OFF_STATUS: prdata_out <= {10'h000, safety_out, 4'h0, relight_count,
                  5'h00, state};
               default: prdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// File: verif/brs_run_seq_asserts.sv
// checker: port assertions of the run-state sequencer
`timescale 1ns/1ps
`default_nettype none
module brs_run_seq_asserts #(
   parameter int unsigned TICK_CYCLES = 4
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire brs_pkg::brs_cond_s cond_in,
   input wire logic [15:0] process_temp_in,
   input wire logic ext_load_in,
   input wire brs_pkg::brs_state_e state_out,
   input wire brs_pkg::brs_safety_s safety_out
);
   // shadow of the settings, rebuilt from apb writes since the checker sees ports only
   logic [1:0] pom;
   logic [15:0] sp_a;
   logic run;
   logic wr;
   assign wr = psel_in && penable_in && pwrite_in;
   assign run = state_out == brs_pkg::BRS_INCIN_NO_ASSIST || state_out == brs_pkg::BRS_PID_CONTROL;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pom <= 2'h0;
         sp_a <= 16'h0000;
      end else if (wr && paddr_in == 12'h000) begin
         pom <= pwdata_in[1:0];
      end else if (wr && paddr_in == 12'h004) begin
         sp_a <= pwdata_in[15:0];
      end
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   a_noassist_valves: assert property (
      state_out == brs_pkg::BRS_INCIN_NO_ASSIST
      |-> !safety_out.first_fuel_shutoff_valve && safety_out.second_fuel_shutoff_valve)
      else $error("no-assist valve pattern wrong");
   a_pid_valves: assert property (
      state_out == brs_pkg::BRS_PID_CONTROL
      |-> safety_out.first_fuel_shutoff_valve && safety_out.second_fuel_shutoff_valve)
      else $error("pid valve pattern wrong");
   // outputs are computed with the mode held before the previous edge
   a_pilot_mode: assert property (
      run |-> safety_out.pilot == ($past(pom) != 2'h2) && safety_out.pilot_valve == safety_out.pilot)
      else $error("pilot outputs disagree with pilot-off mode");
   a_ign_cause: assert property (
      $rose(safety_out.ignition_coil) |-> $past(cond_in.flame_loss, 2))
      else $error("ignition coil rose without flame loss");
   a_ign_pair: assert property (
      safety_out.ignition_coil == safety_out.ignition_enable)
      else $error("coil and ignition enable differ");
   a_assist_off: assert property (
      state_out == brs_pkg::BRS_INCINERATE && cond_in == 5'h00 && !ext_load_in
      && process_temp_in > sp_a |=> state_out == brs_pkg::BRS_INCIN_NO_ASSIST)
      else $error("no move to no-assist");
   a_assist_back: assert property (
      state_out == brs_pkg::BRS_INCIN_NO_ASSIST && cond_in == 5'h00 && process_temp_in < sp_a
      |=> state_out == brs_pkg::BRS_INCINERATE)
      else $error("no return to incinerate");
   a_stop_lock: assert property (
      run && (cond_in.alarm || cond_in.user_stop) |=> state_out == brs_pkg::BRS_LOCKOUT)
      else $error("alarm or stop did not lock out");
   a_wait_exit: assert property (
      run && cond_in.wait_cond && !cond_in.alarm && !cond_in.user_stop && !cond_in.flame_loss
      |=> state_out == brs_pkg::BRS_WAITING)
      else $error("wait condition did not reach waiting");
   a_perm_exit: assert property (
      run && cond_in == 5'b00100 |=> state_out == (pom[1] ? brs_pkg::BRS_WAITING : brs_pkg::BRS_PILOT))
      else $error("main permissive exit wrong");
endmodule
bind brs_run_seq brs_run_seq_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.mclk_in(mclk_in),
   .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .paddr_in(paddr_in), .pwdata_in(pwdata_in), .cond_in(cond_in),
   .process_temp_in(process_temp_in), .ext_load_in(ext_load_in), .state_out(state_out),
   .safety_out(safety_out));
`default_nettype wire

// File: verif/brs_field_model.sv
// field model: flame sensing and process temperature seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module brs_field_model (
   input wire brs_pkg::brs_safety_s safety_in,
   input wire logic lose_flame_in,
   input wire logic [15:0] temp_set_in,
   output logic flame_loss_out,
   output logic [15:0] temp_out
);
   // a burner with no fuel fed has no flame to lose, so loss is reported only while fed
   assign flame_loss_out = lose_flame_in && (safety_in.pilot || safety_in.second_fuel_shutoff_valve);
   assign temp_out = temp_set_in;
endmodule
`default_nettype wire

// File: verif/tb.sv
// testbench of the run-state sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] cb = 4'h0;
   logic lose = 1'b0;
   logic ext_load = 1'b0;
   logic [15:0] tset = 16'h0000;
   logic [15:0] temp;
   logic fl;
   brs_pkg::brs_state_e ext_state = brs_pkg::BRS_LOCKOUT;
   brs_pkg::brs_state_e st;
   brs_pkg::brs_safety_s sf;
   brs_pkg::brs_cond_s cnd;
   int n_errors = 0;
   int cmp_count = 0;
   // exit table: alarm/wait/permissive/stop bits, pilot-off mode, expected state
   logic [3:0] tc [9] = '{4'h8, 4'h1, 4'h4, 4'hc, 4'h2, 4'h2, 4'h2, 4'h2, 4'h6};
   logic [1:0] tp [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
   brs_pkg::brs_state_e te [9] = '{brs_pkg::BRS_LOCKOUT, brs_pkg::BRS_LOCKOUT,
      brs_pkg::BRS_WAITING, brs_pkg::BRS_LOCKOUT, brs_pkg::BRS_PILOT, brs_pkg::BRS_PILOT,
      brs_pkg::BRS_WAITING, brs_pkg::BRS_WAITING, brs_pkg::BRS_WAITING};
   assign cnd = {cb[3:1], fl, cb[0]};
   always #25 mclk = ~mclk;
   brs_run_seq #(.TICK_CYCLES(4)) u_dut (.mclk_in(mclk), .rst_n_in(rst_n), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .cond_in(cnd),
      .process_temp_in(temp), .ext_load_in(ext_load), .ext_state_in(ext_state),
      .state_out(st), .safety_out(sf));
   brs_field_model u_fld (.safety_in(sf), .lose_flame_in(lose), .temp_set_in(tset),
      .flame_loss_out(fl), .temp_out(temp));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic see_st(input brs_pkg::brs_state_e e);
      @(posedge mclk);
      #1;
      cmp("state", 32'(e), 32'(st));
   endtask
   task automatic see_sf(input logic [5:0] e);
      cmp("safety", {26'h0, e}, {26'h0, sf});
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // no cycle count assumed: the wait lasts until pready, and only the watchdog ends a hang
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      cmp("read data", e, rd);
      cmp("slave error", {31'h0, ee}, {31'h0, er});
   endtask
   task automatic put(input logic [3:0] c, input logic [15:0] t);
      @(posedge mclk);
      cb <= c;
      tset <= t;
   endtask
   // an alarm pulse first, since a load is ignored in the two running states
   task automatic goto(input brs_pkg::brs_state_e s);
      put(4'h8, tset);
      put(4'h0, tset);
      ext_load <= 1'b1;
      ext_state <= s;
      @(posedge mclk);
      ext_load <= 1'b0;
   endtask
   task automatic to_noassist;
      put(4'h0, 16'h0032);
      goto(brs_pkg::BRS_INCINERATE);
      put(4'h0, 16'h0096);
      see_st(brs_pkg::BRS_INCIN_NO_ASSIST);
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      $display("unexpected timeout: expected end of tests seen hang");
      close_out;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int k;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      see_sf(6'h00);
      rdc(12'h000, 32'h0000_0300, 1'b0);
      rdc(12'h014, 32'h2710_ea60, 1'b0);
      rdc(12'h01c, 32'h0000_0000, 1'b1);
      wr(12'h004, 32'h0000_0064);
      wr(12'h008, 32'h0000_03e8);
      wr(12'h00c, 32'h0000_01f4);
      wr(12'h010, 32'h0000_0320);
      rdc(12'h004, 32'h0000_0064, 1'b0);
      $display("registers test done");
      to_noassist();
      see_sf(6'b101100);
      wr(12'h000, 32'h0000_0302);
      @(posedge mclk);
      #1;
      see_sf(6'b001000);
      put(4'h0, 16'h0032);
      see_st(brs_pkg::BRS_INCINERATE);
      for (int p = 0; p < 4; p++) begin
         wr(12'h000, 32'h0000_0300 | p);
         to_noassist();
         put(4'h0, 16'h044c);
         see_st(p > 1 ? brs_pkg::BRS_WAITING : brs_pkg::BRS_PILOT);
         put(4'h0, 16'h0190);
         goto(brs_pkg::BRS_LOW_FIRE);
         wr(12'h000, 32'h0000_0310 | p);
         see_st(brs_pkg::BRS_PID_CONTROL);
         see_sf(p == 2 ? 6'b011000 : 6'b111100);
         put(4'h0, 16'h0384);
         see_st(p > 1 ? brs_pkg::BRS_WAITING : brs_pkg::BRS_PILOT);
      end
      $display("temperature exits test done");
      wr(12'h014, 32'h2710_0002);
      for (int m = 1; m < 3; m++) begin
         wr(12'h000, 32'h0000_0310 | (m << 2));
         put(4'h0, 16'h0190);
         goto(brs_pkg::BRS_LOW_FIRE);
         see_st(brs_pkg::BRS_PID_CONTROL);
         put(4'h0, 16'h0258);
         repeat (3) @(posedge mclk);
         #1;
         cmp("state", 32'(brs_pkg::BRS_PID_CONTROL), 32'(st));
         k = 0;
         while (st === brs_pkg::BRS_PID_CONTROL && k < 40) begin
            @(posedge mclk);
            #1;
            k++;
         end
         cmp("state", 32'(m == 1 ? brs_pkg::BRS_WAITING : brs_pkg::BRS_PILOT), 32'(st));
      end
      $display("standby test done");
      for (int i = 0; i < 9; i++) begin
         wr(12'h000, 32'h0000_0300 | tp[i]);
         to_noassist();
         put(tc[i], 16'h0096);
         see_st(te[i]);
      end
      $display("exit priority test done");
      wr(12'h000, 32'h0000_0320);
      for (int i = 0; i < 4; i++) begin
         to_noassist();
         @(posedge mclk);
         lose <= 1'b1;
         see_st(i < 3 ? brs_pkg::BRS_WAITING : brs_pkg::BRS_LOCKOUT);
         if (i == 0) begin
            // the window opens at the loss edge; the coil follows one edge later
            @(posedge mclk);
            #1;
            see_sf(6'b000011);
         end
         @(posedge mclk);
         lose <= 1'b0;
      end
      rdc(12'h018, 32'h0000_0300, 1'b0);
      $display("flame loss test done");
      close_out;
   end
endmodule
`default_nettype wire
